// file: include/pibc_params.svh
// constants for the port transfer and program control decoder
`ifndef PIBC_PARAMS_SVH
`define PIBC_PARAMS_SVH
// ----------------------------------------
// opcode patterns (17-bit instruction words)
// ----------------------------------------
`define PIBC_OP_PORT_MEM 4'hc
`define PIBC_OP_PORT_ACC 5'h1d
`define PIBC_OP_VECTOR_CALL 9'h1fd
`define PIBC_OP_JCC 6'h20
`define PIBC_OP_CCC 6'h21
`define PIBC_OP_JIND 6'h22
`define PIBC_OP_CIND 6'h23
`define PIBC_OP_RET 17'h1ffff
`define PIBC_OP_INTERRUPT_RETURN 17'h1fffe
// ----------------------------------------
// field positions
// ----------------------------------------
`define PIBC_MEM_DIR_BIT 12
`define PIBC_SHORT_PORT_MSB 11
`define PIBC_SHORT_PORT_LSB 8
`define PIBC_STRING_BIT 10
`define PIBC_ACC_SEL_MSB 9
`define PIBC_ACC_SEL_LSB 8
`define PIBC_LONG_PORT_MSB 7
`define PIBC_LONG_PORT_LSB 2
`define PIBC_ACC_DIR_BIT 1
`define PIBC_ACC_INV_BIT 0
`define PIBC_NOT_BIT 10
`define PIBC_CC_MSB 9
`define PIBC_CC_LSB 5
`define PIBC_RX_MSB 4
`define PIBC_RX_LSB 2
// ----------------------------------------
// vector page, stack pointer, reset values
// ----------------------------------------
`define PIBC_VECTOR_PAGE 8'h7f
`define PIBC_PC_RESET 16'h0000
`define PIBC_SP_RESET 16'h0000
// ----------------------------------------
// condition codes
// ----------------------------------------
`define PIBC_CC_Z 5'h00
`define PIBC_CC_S 5'h01
`define PIBC_CC_C 5'h02
`define PIBC_CC_B 5'h03
`define PIBC_CC_A 5'h04
`define PIBC_CC_G 5'h05
`define PIBC_CC_E 5'h06
`define PIBC_CC_O 5'h07
`define PIBC_CC_RC 5'h08
`define PIBC_CC_RA 5'h09
`define PIBC_CC_RE 5'h0a
`define PIBC_CC_REZ 5'h0b
`define PIBC_CC_RLZ 5'h0c
`define PIBC_CC_L 5'h0d
`define PIBC_CC_TF1 5'h10
`define PIBC_CC_TF2 5'h11
`define PIBC_CC_TAG 5'h12
`define PIBC_CC_IN1 5'h13
`define PIBC_CC_IN2 5'h14
`define PIBC_CC_UNC 5'h15
`define PIBC_CC_XS 5'h18
`define PIBC_CC_XZ 5'h19
`define PIBC_CC_XG 5'h1a
`endif

// file: include/pibc_pkg.sv
// types for the port transfer and program control decoder
package pibc_pkg;
	typedef struct packed {
		logic zero_flag;
		logic sign_flag;
		logic carry_flag;
		logic overflow_flag;
		logic reg_compare_carry_flag;
		logic reg_compare_zero_flag;
		logic test_flag_one;
		logic test_flag_two;
		logic tag_bit;
		logic input_status_one;
		logic input_status_two;
		logic extended_sign_flag;
		logic extended_zero_flag;
	} pibc_flags_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [5:0] addr;
		logic [15:0] data;
	} pibc_port_s;

	typedef enum logic [2:0] {
		PIBC_ST_FETCH,
		PIBC_ST_OPERAND,
		PIBC_ST_PUSH,
		PIBC_ST_POP,
		PIBC_ST_PORT_RD
	} pibc_state_e;
endpackage

// file: core/pibc_decoder.sv
// decode and execute of port transfers and program control
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pibc_params.svh"
module pibc_decoder import pibc_pkg::*; (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [16:0] instr_word,
	input wire logic instr_valid,
	input wire logic irq_req,
	input wire logic [7:0] irq_vector,
	input wire logic [15:0] acc_rd_data,
	input wire logic [15:0] aux_reg_value,
	input wire logic [15:0] mem_rd_data,
	input wire logic [15:0] port_rd_data,
	input wire pibc_flags_s status_in,
	input wire logic status_load,
	output logic instr_ack,
	output logic [15:0] pc,
	output logic [15:0] stack_pointer_reg,
	output logic [1:0] accumulator_select,
	output logic acc_wr,
	output logic [15:0] acc_wr_data,
	output logic mem_rd,
	output logic mem_wr,
	output logic [15:0] mem_addr_sel,
	output logic [15:0] mem_wr_data,
	output logic mem_from_mode,
	output pibc_port_s port_req,
	output logic xfer_status_upd,
	output logic alu_status_upd,
	output logic string_mode,
	output logic irq_ack,
	output pibc_flags_s flags
);
	// ----------------------------------------
	// condition evaluation
	// ----------------------------------------
	function automatic logic cond_raw(input logic [4:0] cc, input pibc_flags_s f,
			input logic [15:0] rx);
		case (cc)
			`PIBC_CC_Z: cond_raw = f.zero_flag;
			`PIBC_CC_S: cond_raw = f.sign_flag;
			`PIBC_CC_C: cond_raw = f.carry_flag;
			`PIBC_CC_B: cond_raw = !f.zero_flag && !f.carry_flag;
			`PIBC_CC_A: cond_raw = !f.zero_flag && f.carry_flag;
			`PIBC_CC_G: cond_raw = !f.sign_flag && !f.zero_flag;
			`PIBC_CC_E: cond_raw = f.zero_flag && !f.overflow_flag;
			`PIBC_CC_O: cond_raw = f.overflow_flag;
			`PIBC_CC_RC: cond_raw = f.reg_compare_carry_flag;
			`PIBC_CC_RA: cond_raw = !f.reg_compare_zero_flag && f.reg_compare_carry_flag;
			`PIBC_CC_RE: cond_raw = f.reg_compare_zero_flag;
			`PIBC_CC_REZ: cond_raw = (rx == 16'h0000);
			`PIBC_CC_RLZ: cond_raw = rx[15];
			`PIBC_CC_L: cond_raw = !f.zero_flag && f.sign_flag;
			`PIBC_CC_TF1: cond_raw = f.test_flag_one;
			`PIBC_CC_TF2: cond_raw = f.test_flag_two;
			`PIBC_CC_TAG: cond_raw = f.tag_bit;
			`PIBC_CC_IN1: cond_raw = f.input_status_one;
			`PIBC_CC_IN2: cond_raw = f.input_status_two;
			`PIBC_CC_UNC: cond_raw = 1'b1;
			`PIBC_CC_XS: cond_raw = f.extended_sign_flag;
			`PIBC_CC_XZ: cond_raw = f.extended_zero_flag;
			`PIBC_CC_XG: cond_raw = !f.extended_sign_flag && !f.extended_zero_flag;
			default: cond_raw = 1'b0;
		endcase
	endfunction

	// reserved codes never taken whatever the invert bit says
	function automatic logic cond_legal(input logic [4:0] cc, input logic is_call);
		case (cc)
			5'h0e, 5'h0f, 5'h16, 5'h17: cond_legal = 1'b0;
			`PIBC_CC_REZ, `PIBC_CC_RLZ: cond_legal = !is_call;
			default: cond_legal = (cc <= `PIBC_CC_XG);
		endcase
	endfunction

	// program counter step only; the stack pointer steps are written out inline
	function automatic logic [15:0] word_inc(input logic [15:0] w);
		word_inc = w + 16'h0001;
	endfunction

	// ----------------------------------------
	// decode of the current word
	// ----------------------------------------
	logic [16:0] iw;
	logic is_port_mem;
	logic is_port_acc;
	logic is_vector_call;
	logic is_jcc;
	logic is_ccc;
	logic is_jind;
	logic is_cind;
	logic is_ret;
	logic is_interrupt_return;
	logic cond_true;
	logic [15:0] pc_plus1;
	pibc_state_e state;
	logic [15:0] target_hold;
	logic pend_call;
	logic pend_taken;
	logic pend_port_dir;
	// port form kept so the second cycle never depends on the word still standing
	logic pend_port_mem;

	assign iw = instr_word;
	assign is_port_mem = (iw[16:13] == `PIBC_OP_PORT_MEM);
	assign is_port_acc = (iw[16:12] == `PIBC_OP_PORT_ACC) && iw[11];
	assign is_vector_call = (iw[16:8] == `PIBC_OP_VECTOR_CALL);
	assign is_ret = (iw == `PIBC_OP_RET);
	assign is_interrupt_return = (iw == `PIBC_OP_INTERRUPT_RETURN);
	assign is_jcc = (iw[16:11] == `PIBC_OP_JCC);
	assign is_ccc = (iw[16:11] == `PIBC_OP_CCC);
	assign is_jind = (iw[16:11] == `PIBC_OP_JIND);
	assign is_cind = (iw[16:11] == `PIBC_OP_CIND);
	assign pc_plus1 = word_inc(pc);
	// invert bit flips the tested sense
	assign cond_true = cond_legal(iw[`PIBC_CC_MSB:`PIBC_CC_LSB], is_ccc)
		&& (cond_raw(iw[`PIBC_CC_MSB:`PIBC_CC_LSB], flags, aux_reg_value)
		^ iw[`PIBC_NOT_BIT]);

	// ----------------------------------------
	// latched status flags
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			flags <= '0;
		end else if (status_load) begin
			flags <= status_in;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state <= PIBC_ST_FETCH;
			pc <= `PIBC_PC_RESET;
			stack_pointer_reg <= `PIBC_SP_RESET;
			target_hold <= 16'h0000;
			pend_call <= 1'b0;
			pend_taken <= 1'b0;
			pend_port_dir <= 1'b0;
			pend_port_mem <= 1'b0;
			instr_ack <= 1'b0;
			accumulator_select <= 2'h0;
			acc_wr <= 1'b0;
			acc_wr_data <= 16'h0000;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr_sel <= 16'h0000;
			mem_wr_data <= 16'h0000;
			mem_from_mode <= 1'b0;
			port_req <= '0;
			xfer_status_upd <= 1'b0;
			alu_status_upd <= 1'b0;
			string_mode <= 1'b0;
			irq_ack <= 1'b0;
		end else begin
			instr_ack <= 1'b0;
			acc_wr <= 1'b0;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_from_mode <= 1'b0;
			port_req.valid <= 1'b0;
			xfer_status_upd <= 1'b0;
			alu_status_upd <= 1'b0;
			irq_ack <= 1'b0;
			case (state)
				PIBC_ST_FETCH: begin
					if (irq_req) begin
						// interrupt entry pushes pc itself, not pc + 1 as a vector call does, then loads the vector the same way
						irq_ack <= 1'b1;
						target_hold <= {`PIBC_VECTOR_PAGE, irq_vector};
						state <= PIBC_ST_PUSH;
						stack_pointer_reg <= stack_pointer_reg + 16'h0001;
						mem_wr <= 1'b1;
						mem_addr_sel <= stack_pointer_reg + 16'h0001;
						mem_wr_data <= pc;
					end else if (instr_valid) begin
						instr_ack <= 1'b1;
						if (is_port_mem) begin
							port_req.addr <= {2'b00,
								iw[`PIBC_SHORT_PORT_MSB:`PIBC_SHORT_PORT_LSB]};
							pc <= pc_plus1;
							pend_port_mem <= 1'b1;
							if (iw[`PIBC_MEM_DIR_BIT]) begin
								// write: memory word first, port next cycle
								mem_rd <= 1'b1;
								mem_from_mode <= 1'b1;
								pend_port_dir <= 1'b1;
							end else begin
								port_req.valid <= 1'b1;
								port_req.write <= 1'b0;
								pend_port_dir <= 1'b0;
							end
							state <= PIBC_ST_PORT_RD;
						end else if (is_port_acc) begin
							// full 6-bit port space
							port_req.addr <= iw[`PIBC_LONG_PORT_MSB:`PIBC_LONG_PORT_LSB];
							accumulator_select <= iw[`PIBC_ACC_SEL_MSB:`PIBC_ACC_SEL_LSB];
							string_mode <= iw[`PIBC_STRING_BIT];
							pc <= pc_plus1;
							if (iw[`PIBC_ACC_DIR_BIT]) begin
								port_req.valid <= 1'b1;
								port_req.write <= 1'b1;
								port_req.data <= acc_rd_data;
								xfer_status_upd <= 1'b1;
							end else begin
								port_req.valid <= 1'b1;
								port_req.write <= 1'b0;
								pend_port_dir <= 1'b0;
								pend_port_mem <= 1'b0;
								state <= PIBC_ST_PORT_RD;
							end
						end else if (is_vector_call) begin
							// single word, second cycle loads vector
							target_hold <= {`PIBC_VECTOR_PAGE, iw[7:0]};
							stack_pointer_reg <= stack_pointer_reg + 16'h0001;
							mem_wr <= 1'b1;
							mem_addr_sel <= stack_pointer_reg + 16'h0001;
							mem_wr_data <= pc_plus1;
							state <= PIBC_ST_PUSH;
						end else if (is_jcc || is_ccc) begin
							pend_call <= is_ccc;
							pend_taken <= cond_true;
							pc <= pc_plus1;
							state <= PIBC_ST_OPERAND;
						end else if (is_jind) begin
							accumulator_select <= iw[9:8];
							pc <= acc_rd_data;
						end else if (is_cind) begin
							accumulator_select <= iw[9:8];
							target_hold <= acc_rd_data;
							stack_pointer_reg <= stack_pointer_reg + 16'h0001;
							mem_wr <= 1'b1;
							mem_addr_sel <= stack_pointer_reg + 16'h0001;
							mem_wr_data <= pc_plus1;
							state <= PIBC_ST_PUSH;
						end else if (is_ret || is_interrupt_return) begin
							// same path serves vector-call returns
							mem_rd <= 1'b1;
							mem_addr_sel <= stack_pointer_reg;
							state <= PIBC_ST_POP;
						end else begin
							pc <= pc_plus1;
						end
					end
				end
				PIBC_ST_OPERAND: begin
					if (instr_valid) begin
						instr_ack <= 1'b1;
						if (pend_taken && pend_call) begin
							target_hold <= iw[15:0];
							stack_pointer_reg <= stack_pointer_reg + 16'h0001;
							mem_wr <= 1'b1;
							mem_addr_sel <= stack_pointer_reg + 16'h0001;
							mem_wr_data <= pc_plus1;
							state <= PIBC_ST_PUSH;
						end else begin
							pc <= pend_taken ? iw[15:0] : pc_plus1;
							state <= PIBC_ST_FETCH;
						end
					end
				end
				PIBC_ST_PUSH: begin
					pc <= target_hold;
					state <= PIBC_ST_FETCH;
				end
				PIBC_ST_POP: begin
					// a return landing on a return is not guarded
					pc <= mem_rd_data;
					stack_pointer_reg <= stack_pointer_reg - 16'h0001;
					state <= PIBC_ST_FETCH;
				end
				PIBC_ST_PORT_RD: begin
					if (pend_port_dir) begin
						port_req.valid <= 1'b1;
						port_req.write <= 1'b1;
						port_req.data <= mem_rd_data;
						xfer_status_upd <= 1'b1;
					end else if (pend_port_mem) begin
						mem_wr <= 1'b1;
						mem_from_mode <= 1'b1;
						mem_wr_data <= port_rd_data;
						xfer_status_upd <= 1'b1;
					end else begin
						acc_wr <= 1'b1;
						acc_wr_data <= port_rd_data;
						alu_status_upd <= 1'b1;
					end
					state <= PIBC_ST_FETCH;
				end
				default: state <= PIBC_ST_FETCH;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: testbench/pibc_far_model.sv
// far side model: data memory, stack words and expansion ports
`timescale 1ns/1ps
`default_nettype none
module pibc_far_model import pibc_pkg::*; #(
	parameter logic [15:0] MODE_WORD = 16'h3c5a
) (
	input wire logic mclk,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr_sel,
	input wire logic [15:0] mem_wr_data,
	input wire logic mem_from_mode,
	input wire pibc_port_s port_req,
	output logic [15:0] mem_rd_data,
	output logic [15:0] port_rd_data
);
	logic [15:0] mem [0:63];
	logic [15:0] m_last = 16'h0;
	logic [15:0] p_last = 16'h0;
	logic m_hold = 1'b0;
	logic p_hold = 1'b0;
	logic p_rd;
	logic [15:0] m_word;
	assign p_rd = port_req.valid && !port_req.write;
	assign m_word = mem_from_mode ? MODE_WORD : mem[mem_addr_sel[5:0]];
	// data kept one cycle past the strobe, then inverted so stale data never passes
	assign mem_rd_data = mem_rd ? m_word : (m_hold ? m_last : ~m_last);
	assign port_rd_data = p_rd ? (16'hc300 | {10'h0, port_req.addr}) : (p_hold ? p_last : ~p_last);
	always @(posedge mclk) begin
		m_hold <= mem_rd;
		p_hold <= p_rd;
		if (mem_rd)
			m_last <= m_word;
		if (p_rd)
			p_last <= port_rd_data;
		if (mem_wr && !mem_from_mode)
			mem[mem_addr_sel[5:0]] <= mem_wr_data;
	end
endmodule
`default_nettype wire

// file: testbench/pibc_decoder_asserts.sv
// stack, vector, status and flag checker for the decoder
`timescale 1ns/1ps
`default_nettype none
`include "pibc_params.svh"
module pibc_decoder_asserts import pibc_pkg::*; (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [16:0] instr_word,
	input wire logic instr_ack,
	input wire logic [7:0] irq_vector,
	input wire logic irq_ack,
	input wire pibc_flags_s status_in,
	input wire logic status_load,
	input wire logic [15:0] pc,
	input wire logic [15:0] stack_pointer_reg,
	input wire logic acc_wr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr_sel,
	input wire logic [15:0] mem_wr_data,
	input wire logic mem_from_mode,
	input wire pibc_port_s port_req,
	input wire logic xfer_status_upd,
	input wire logic alu_status_upd,
	input wire pibc_flags_s flags
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic [7:0] vec_q;
	logic is_vc;
	assign is_vc = instr_ack && instr_word[16:8] == `PIBC_OP_VECTOR_CALL;
	always_ff @(posedge mclk) begin
		vec_q <= instr_word[7:0];
	end
	chk_vector_call_push: assert property (is_vc |-> mem_wr && mem_wr_data == pc + 16'h1 &&
		stack_pointer_reg == $past(stack_pointer_reg) + 16'h1 && mem_addr_sel == stack_pointer_reg)
		else $error("vector call push wrong");
	chk_vector_call_target: assert property (is_vc |=> pc == {`PIBC_VECTOR_PAGE, vec_q})
		else $error("vector call target wrong");
	chk_ret_pop: assert property (instr_ack && (instr_word == `PIBC_OP_RET ||
		instr_word == `PIBC_OP_INTERRUPT_RETURN) |-> mem_rd && mem_addr_sel == stack_pointer_reg)
		else $error("return pop address wrong");
	chk_sp_step: assert property ($changed(stack_pointer_reg) |->
		stack_pointer_reg == $past(stack_pointer_reg) + 16'h1 ||
		stack_pointer_reg == $past(stack_pointer_reg) - 16'h1)
		else $error("stack pointer jumped");
	chk_irq_vector: assert property (irq_ack |-> ##[0:2] pc == {`PIBC_VECTOR_PAGE, irq_vector})
		else $error("interrupt vector wrong");
	chk_acc_read_alu: assert property (acc_wr |-> alu_status_upd && !xfer_status_upd)
		else $error("accumulator read status wrong");
	chk_mode_write_xfer: assert property (mem_wr && mem_from_mode |-> xfer_status_upd)
		else $error("memory port read status wrong");
	chk_port_wr_xfer: assert property (port_req.valid && port_req.write |-> ##[0:2] xfer_status_upd)
		else $error("port write status missing");
	chk_flags_load: assert property (status_load |=> flags == $past(status_in))
		else $error("flags not loaded");
	chk_flags_hold: assert property (!status_load |=> $stable(flags))
		else $error("flags changed unloaded");
endmodule
bind pibc_decoder pibc_decoder_asserts u_chk (.mclk(mclk), .nrst(nrst), .instr_word(instr_word),
	.instr_ack(instr_ack), .irq_vector(irq_vector), .irq_ack(irq_ack), .status_in(status_in),
	.status_load(status_load), .pc(pc), .stack_pointer_reg(stack_pointer_reg), .acc_wr(acc_wr),
	.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr_sel(mem_addr_sel), .mem_wr_data(mem_wr_data),
	.mem_from_mode(mem_from_mode), .port_req(port_req), .xfer_status_upd(xfer_status_upd),
	.alu_status_upd(alu_status_upd), .flags(flags));
`default_nettype wire

// file: testbench/pibc_decoder_tb.sv
// self-checking bench for the port and program control decoder
`timescale 1ns/1ps
`default_nettype none
`include "pibc_params.svh"
module pibc_decoder_tb import pibc_pkg::*; ;
	logic mclk = 0, nrst = 0, instr_valid = 0, irq_req = 0, status_load = 0;
	logic [16:0] instr_word = '0;
	logic [7:0] irq_vector = '0;
	logic [15:0] acc_rd_data = '0, aux_reg_value = '0;
	pibc_flags_s status_in = '0;
	logic [15:0] mem_rd_data, port_rd_data, pc, sp, acc_wr_data, mem_addr_sel, mem_wr_data;
	logic instr_ack, acc_wr, mem_rd, mem_wr, mem_from_mode, xfer_status_upd, alu_status_upd;
	logic string_mode, irq_ack, wm, pw, sm;
	logic [1:0] acc_sel;
	pibc_port_s port_req;
	pibc_flags_s flags;
	int mismatches = 0, checks_done = 0, nx = 0, na = 0;
	logic [15:0] exp_pc = '0, exp_sp = '0, wd, pd, ad;
	logic [5:0] pa;
	logic [12:0] pats [3] = '{13'h0000, 13'h1fff, 13'h0b4d};
	logic [15:0] auxs [3] = '{16'h0000, 16'h8000, 16'h0001};
	logic [5:0] adrs [4] = '{6'd0, 6'd15, 6'd16, 6'd63};
	pibc_decoder dut (.mclk(mclk), .nrst(nrst), .instr_word(instr_word), .instr_valid(instr_valid),
		.irq_req(irq_req), .irq_vector(irq_vector), .acc_rd_data(acc_rd_data),
		.aux_reg_value(aux_reg_value), .mem_rd_data(mem_rd_data), .port_rd_data(port_rd_data),
		.status_in(status_in), .status_load(status_load), .instr_ack(instr_ack), .pc(pc),
		.stack_pointer_reg(sp), .accumulator_select(acc_sel), .acc_wr(acc_wr),
		.acc_wr_data(acc_wr_data), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr_sel(mem_addr_sel),
		.mem_wr_data(mem_wr_data), .mem_from_mode(mem_from_mode), .port_req(port_req),
		.xfer_status_upd(xfer_status_upd), .alu_status_upd(alu_status_upd),
		.string_mode(string_mode), .irq_ack(irq_ack), .flags(flags));
	pibc_far_model far (.mclk(mclk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr_sel(mem_addr_sel),
		.mem_wr_data(mem_wr_data), .mem_from_mode(mem_from_mode), .port_req(port_req),
		.mem_rd_data(mem_rd_data), .port_rd_data(port_rd_data));
	initial begin
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (mem_wr) begin
			wd <= mem_wr_data;
			wm <= mem_from_mode;
		end
		if (port_req.valid) begin
			pa <= port_req.addr;
			pd <= port_req.data;
			pw <= port_req.write;
		end
		if (acc_wr) begin
			ad <= acc_wr_data;
			sm <= string_mode;
		end
		nx <= nx + int'(xfer_status_upd);
		na <= na + int'(alu_status_upd);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// word taken at the first edge since the decoder is idle; valid dropped at once
	task automatic issue(input logic [16:0] w);
		int n;
		instr_word <= w;
		instr_valid <= 1'b1;
		@(posedge mclk);
		instr_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (instr_ack !== 1'b1 && n < 8);
		check(instr_ack, 1);
		repeat (3) @(posedge mclk);
	endtask
	// return lands after the call site (on the interrupted pc for an interrupt entry), never on another return
	task automatic call_ret(input logic [16:0] w, input logic [16:0] op, input bit two,
		input logic [15:0] dest, input bit irq);
		logic [15:0] ra;
		int n;
		ra = irq ? exp_pc : exp_pc + (two ? 16'h2 : 16'h1);
		if (irq) begin
			irq_req <= 1'b1;
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (irq_ack !== 1'b1 && n < 8);
			irq_req <= 1'b0;
			repeat (3) @(posedge mclk);
		end else
			issue(w);
		if (two)
			issue(op);
		check(wd, ra);
		check(sp, exp_sp + 16'h1);
		check(pc, dest);
		issue(irq ? `PIBC_OP_INTERRUPT_RETURN : `PIBC_OP_RET);
		check(pc, ra);
		check(sp, exp_sp);
		exp_pc = ra;
	endtask
	function automatic logic taken(input logic [4:0] c, input logic nb, input pibc_flags_s f,
		input logic [15:0] x);
		logic [31:0] v;
		v = {5'h0, !f.extended_sign_flag && !f.extended_zero_flag, f.extended_zero_flag,
			f.extended_sign_flag, 2'h0, 1'b1, f.input_status_two, f.input_status_one, f.tag_bit,
			f.test_flag_two, f.test_flag_one, 2'h0, !f.zero_flag && f.sign_flag, x[15], x == 16'h0,
			f.reg_compare_zero_flag, !f.reg_compare_zero_flag && f.reg_compare_carry_flag,
			f.reg_compare_carry_flag, f.overflow_flag, f.zero_flag && !f.overflow_flag,
			!f.sign_flag && !f.zero_flag, !f.zero_flag && f.carry_flag,
			!f.zero_flag && !f.carry_flag, f.carry_flag, f.sign_flag, f.zero_flag};
		return 32'h073f3fff >> c & 1 ? v[c] ^ nb : 1'b0;
	endfunction
	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end
	initial begin
		logic [15:0] t, u;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		check(pc, 16'h0);
		check(sp, 16'h0);
		for (int p = 0; p < 3; p++) begin
			status_in <= pibc_flags_s'(pats[p]);
			status_load <= 1'b1;
			aux_reg_value <= auxs[p];
			@(posedge mclk);
			status_load <= 1'b0;
			status_in <= pibc_flags_s'(~pats[p]);
			for (int c = 0; c < 64; c++) begin
				t = exp_pc + 16'h11;
				issue({`PIBC_OP_JCC, c[0], c[5:1], 5'h0});
				issue({1'b0, t});
				exp_pc = taken(c[5:1], c[0], pibc_flags_s'(pats[p]), auxs[p]) ? t : exp_pc + 16'h2;
				check(pc, exp_pc);
			end
			check(flags, pats[p]);
		end
		for (int i = 0; i < 2; i++) begin
			aux_reg_value <= auxs[i];
			issue({`PIBC_OP_CCC, 1'b0, 5'h0b + 5'(i), 5'h0});
			issue(17'h00400);
			exp_pc = exp_pc + 16'h2;
			check(pc, exp_pc);
			check(sp, exp_sp);
		end
		issue({`PIBC_OP_CCC, 1'b1, 5'h1b, 5'h0});
		issue(17'h00400);
		exp_pc = exp_pc + 16'h2;
		check(pc, exp_pc);
		check(sp, exp_sp);
		call_ret({`PIBC_OP_VECTOR_CALL, 8'h3c}, '0, 0, 16'h7f3c, 0);
		call_ret({`PIBC_OP_VECTOR_CALL, 8'hff}, '0, 0, 16'h7fff, 0);
		call_ret({`PIBC_OP_CCC, 1'b0, `PIBC_CC_UNC, 5'h0}, 17'h00222, 1, 16'h0222, 0);
		acc_rd_data <= 16'h0abc;
		call_ret({`PIBC_OP_CIND, 11'h0}, '0, 0, 16'h0abc, 0);
		irq_vector <= 8'h21;
		call_ret('0, '0, 0, 16'h7f21, 1);
		issue({`PIBC_OP_JIND, 11'h0});
		check(pc, 16'h0abc);
		u = na[15:0];
		for (int i = 0; i < 8; i++) begin
			t = {nx[15:0]};
			acc_rd_data <= 16'h1234 ^ 16'(adrs[i / 2]);
			issue({`PIBC_OP_PORT_ACC, 1'b1, i[0], 2'h2, adrs[i / 2], i[1], 1'b0});
			check(pa, adrs[i / 2]);
			check(i[1] ? pd : ad, i[1] ? 16'h1234 ^ 16'(adrs[i / 2]) : 16'hc300 | 16'(adrs[i / 2]));
			check(nx[15:0], t + 16'(i[1]));
			if (!i[1])
				check(sm, i[0]);
		end
		check(na[15:0], u + 16'h4);
		t = nx[15:0];
		issue({`PIBC_OP_PORT_MEM, 1'b0, 4'h5, 8'h0});
		check({pa, pw, wm, wd}, {6'h05, 1'b0, 1'b1, 16'hc305});
		issue({`PIBC_OP_PORT_MEM, 1'b1, 4'h9, 8'h0});
		check({pa, pw, pd}, {6'h09, 1'b1, 16'h3c5a});
		check(nx[15:0], t + 16'h2);
		report_and_stop();
	end
endmodule
`default_nettype wire
